//--- src/bcw_pkg.sv
// Constants and types of the message control word interpreter.
// Assumes 16-bit shared memory words and 16-bit registers on a byte-addressed port.
package bcw_pkg;
  // ********************************
  // Register map
  // ********************************
  localparam logic [7:0] ADDR_CTL = 8'h04;
  localparam logic [7:0] ADDR_CFG1 = 8'h08;
  localparam logic [7:0] ADDR_CFG3 = 8'h0C;
  localparam logic [7:0] ADDR_CFG4 = 8'h10;
  localparam logic [7:0] ADDR_STAT = 8'h14;
  localparam logic [15:0] RST_CTL = 16'h0000;
  localparam logic [15:0] RST_CFG = 16'h0000;
  // ********************************
  // Control word fields
  // ********************************
  localparam int CW_ME_MASK = 14;
  localparam int CW_SR_MASK = 13;
  localparam int CW_BUSY_MASK = 12;
  localparam int CW_SSF_MASK = 11;
  localparam int CW_TF_MASK = 10;
  localparam int CW_RSV_MASK = 9;
  localparam int CW_RETRY = 8;
  localparam int CW_CHAN_A = 7;
  localparam int CW_SELF_TEST = 6;
  localparam int CW_BCST_MASK = 5;
  localparam int CW_EOM_IRQ = 4;
  localparam int CW_LEGACY = 3;
  localparam int CW_FMT_LO = 0;
  // ********************************
  // Configuration fields
  // ********************************
  localparam int CF1_RETRY_EN = 4;
  localparam int CF1_DOUBLE = 3;
  localparam int CF3_ENH = 15;
  localparam int CF4_WIDE = 12;
  localparam int CF4_BMASK_EN = 11;
  localparam int CF4_RETRY_LEGACY = 10;
  localparam int CF4_RETRY_STAT = 9;
  // ********************************
  // Status and command word fields
  // ********************************
  localparam int SW_ADDR_LO = 11;
  localparam int SW_ME = 10;
  localparam int SW_INSTR = 9;
  localparam int SW_SR = 8;
  localparam int SW_RSV_LO = 5;
  localparam int SW_BCR = 4;
  localparam int SW_BUSY = 3;
  localparam int SW_SSF = 2;
  localparam int SW_DBCA = 1;
  localparam int SW_TF = 0;
  localparam int CMD_TR = 10;
  // ********************************
  // Message block offsets and types
  // ********************************
  localparam logic [15:0] OFS_CMD = 16'h0001;
  localparam logic [15:0] OFS_MC_STAT = 16'h0003;
  typedef enum logic [2:0] {ST_IDLE, ST_RD_CTL, ST_RD_CMD, ST_DECODE, ST_RUN} bcw_state_e;
  typedef enum logic [2:0] {FMT_BC_RT, FMT_RT_BC, FMT_TERMINAL_PAIR, FMT_BCST, FMT_BCST_PAIR,
                            FMT_MODE, FMT_BCST_MODE, FMT_UNUSED} bcw_fmt_e;
  typedef struct packed {
    logic chan_a;
    logic tx_inhibit;
    logic loop_en;
    logic bcst_expect;
    logic end_of_msg_irq_en;
    logic legacy_standard_select;
    bcw_fmt_e fmt;
  } bcw_msg_s;
endpackage : bcw_pkg

//--- src/bcw_ctrl.sv
// Message control word interpreter: fetches and latches each message's control word,
// decodes format and channel, checks responding terminal status and qualifies retries.
// Assumes shared memory answers a read one cycle after the read strobe.
`timescale 1ns/100ps
module bcw_ctrl (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // Register port
  input wire logic [7:0] i_reg_addr,
  input wire logic [15:0] i_reg_wdata,
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  output logic [15:0] o_reg_rdata,
  // Shared memory read port
  output logic o_mem_rd,
  output logic [15:0] o_mem_addr,
  input wire logic [15:0] i_mem_data,
  // Message sequencing
  input wire logic i_msg_start,
  input wire logic [15:0] i_msg_base,
  input wire logic i_status_valid,
  input wire logic [15:0] i_status_word,
  input wire logic i_attempt_end,
  input wire logic i_resp_timeout,
  input wire logic i_format_error,
  // Decoded message control
  output bcw_pkg::bcw_msg_s o_msg,
  output logic o_msg_valid,
  output logic [15:0] o_tx_addr,
  output logic [15:0] o_mc_stat_addr,
  output logic o_status_set,
  output logic o_retry,
  output logic o_msg_done
);
  // ********************************
  // Status check
  // ********************************
  function automatic logic stat_check(input logic [15:0] sw, input logic [15:0] cw,
                                      input logic [4:0] exp_addr, input logic wide,
                                      input logic bmask_en);
    logic hit;
    hit = sw[15:bcw_pkg::SW_ADDR_LO] != exp_addr;
    if (!wide) begin
      hit = hit | sw[bcw_pkg::SW_ME] | sw[bcw_pkg::SW_INSTR] | sw[bcw_pkg::SW_SR];
      hit = hit | sw[bcw_pkg::SW_BUSY] | sw[bcw_pkg::SW_SSF] | sw[bcw_pkg::SW_DBCA] | sw[bcw_pkg::SW_TF];
      hit = hit | (sw[bcw_pkg::SW_BCR] ^ cw[bcw_pkg::CW_BCST_MASK]);
    end else begin
      // Bits without a mask of their own always count
      hit = hit | sw[bcw_pkg::SW_INSTR] | sw[bcw_pkg::SW_DBCA];
      hit = hit | (sw[bcw_pkg::SW_ME] & ~cw[bcw_pkg::CW_ME_MASK]);
      hit = hit | (sw[bcw_pkg::SW_SR] & ~cw[bcw_pkg::CW_SR_MASK]);
      hit = hit | (sw[bcw_pkg::SW_BUSY] & ~cw[bcw_pkg::CW_BUSY_MASK]);
      hit = hit | (sw[bcw_pkg::SW_SSF] & ~cw[bcw_pkg::CW_SSF_MASK]);
      hit = hit | (sw[bcw_pkg::SW_TF] & ~cw[bcw_pkg::CW_TF_MASK]);
      hit = hit | ((|sw[bcw_pkg::SW_RSV_LO +: 3]) & ~cw[bcw_pkg::CW_RSV_MASK]);
      if (bmask_en) begin
        hit = hit | (sw[bcw_pkg::SW_BCR] & ~cw[bcw_pkg::CW_BCST_MASK]);
      end else begin
        hit = hit | (sw[bcw_pkg::SW_BCR] ^ cw[bcw_pkg::CW_BCST_MASK]);
      end
    end
    return hit;
  endfunction : stat_check

  // ********************************
  // State
  // ********************************
  bcw_pkg::bcw_state_e state_r, state_nxt;
  logic [15:0] ctl_r, ctl_nxt;
  logic [15:0] cmd_r, cmd_nxt;
  logic [15:0] base_r, base_nxt;
  logic [15:0] cfg1_r, cfg1_nxt;
  logic [15:0] cfg3_r, cfg3_nxt;
  logic [15:0] cfg4_r, cfg4_nxt;
  logic wide_r, wide_nxt;
  logic stat_set_r, stat_set_nxt;
  logic me_r, me_nxt;
  logic [1:0] cnt_r, cnt_nxt;
  logic [15:0] rdata_r, rdata_nxt;
  logic mem_rd_r, mem_rd_nxt;
  logic [15:0] mem_addr_r, mem_addr_nxt;
  logic [15:0] tx_addr_r, tx_addr_nxt;
  logic [15:0] mc_addr_r, mc_addr_nxt;
  bcw_pkg::bcw_msg_s msg_r, msg_nxt;
  logic valid_r, valid_nxt;
  logic retry_r, retry_nxt;
  logic done_r, done_nxt;
  logic [1:0] max_retry;
  logic msg_retry;
  logic base_ok;
  logic need;

  assign max_retry = cfg1_r[bcw_pkg::CF1_DOUBLE] ? 2'h2 : 2'h1;
  // Short form leaves the per-message retry bit out, so only the global enable decides
  assign msg_retry = wide_r ? ctl_r[bcw_pkg::CW_RETRY] : 1'b1;
  assign base_ok = cfg1_r[bcw_pkg::CF1_RETRY_EN] & msg_retry;

  // ********************************
  // Next state
  // ********************************
  always_comb begin
    state_nxt = state_r;
    ctl_nxt = ctl_r;
    cmd_nxt = cmd_r;
    base_nxt = base_r;
    cfg1_nxt = cfg1_r;
    cfg3_nxt = cfg3_r;
    cfg4_nxt = cfg4_r;
    wide_nxt = wide_r;
    stat_set_nxt = stat_set_r;
    me_nxt = me_r;
    cnt_nxt = cnt_r;
    rdata_nxt = 16'h0000;
    mem_rd_nxt = 1'b0;
    mem_addr_nxt = mem_addr_r;
    tx_addr_nxt = tx_addr_r;
    mc_addr_nxt = mc_addr_r;
    msg_nxt = msg_r;
    valid_nxt = valid_r;
    retry_nxt = 1'b0;
    done_nxt = 1'b0;
    need = 1'b0;
    if (i_reg_wr) begin
      unique case (i_reg_addr)
        // The control word is held steady while a message runs
        bcw_pkg::ADDR_CTL: if (state_r == bcw_pkg::ST_IDLE) ctl_nxt = i_reg_wdata;
        bcw_pkg::ADDR_CFG1: cfg1_nxt = i_reg_wdata;
        bcw_pkg::ADDR_CFG3: cfg3_nxt = i_reg_wdata;
        bcw_pkg::ADDR_CFG4: cfg4_nxt = i_reg_wdata;
        default: ;
      endcase
    end
    if (i_reg_rd) begin
      unique case (i_reg_addr)
        bcw_pkg::ADDR_CTL: rdata_nxt = ctl_r;
        bcw_pkg::ADDR_CFG1: rdata_nxt = cfg1_r;
        bcw_pkg::ADDR_CFG3: rdata_nxt = cfg3_r;
        bcw_pkg::ADDR_CFG4: rdata_nxt = cfg4_r;
        bcw_pkg::ADDR_STAT: rdata_nxt = {11'h000, cnt_r, stat_set_r, valid_r, state_r != bcw_pkg::ST_IDLE};
        default: rdata_nxt = 16'h0000;
      endcase
    end
    unique case (state_r)
      bcw_pkg::ST_IDLE: begin
        if (i_msg_start) begin
          base_nxt = i_msg_base;
          mem_rd_nxt = 1'b1;
          mem_addr_nxt = i_msg_base;
          valid_nxt = 1'b0;
          cnt_nxt = 2'h0;
          stat_set_nxt = 1'b0;
          me_nxt = 1'b0;
          state_nxt = bcw_pkg::ST_RD_CTL;
        end
      end
      bcw_pkg::ST_RD_CTL: begin
        // Command read follows straight on, so each word is taken in the one cycle it stands
        mem_rd_nxt = 1'b1;
        mem_addr_nxt = base_r + bcw_pkg::OFS_CMD;
        state_nxt = bcw_pkg::ST_RD_CMD;
      end
      bcw_pkg::ST_RD_CMD: begin
        ctl_nxt = i_mem_data;
        wide_nxt = cfg3_r[bcw_pkg::CF3_ENH] & cfg4_r[bcw_pkg::CF4_WIDE];
        state_nxt = bcw_pkg::ST_DECODE;
      end
      bcw_pkg::ST_DECODE: begin
        cmd_nxt = i_mem_data;
        // Bus traffic starts after the control word, which stays local
        tx_addr_nxt = base_r + bcw_pkg::OFS_CMD;
        mc_addr_nxt = base_r + bcw_pkg::OFS_MC_STAT;
        msg_nxt.chan_a = ctl_r[bcw_pkg::CW_CHAN_A];
        msg_nxt.tx_inhibit = ctl_r[bcw_pkg::CW_SELF_TEST];
        msg_nxt.loop_en = ctl_r[bcw_pkg::CW_SELF_TEST];
        msg_nxt.bcst_expect = ctl_r[bcw_pkg::CW_BCST_MASK];
        msg_nxt.end_of_msg_irq_en = wide_r & ctl_r[bcw_pkg::CW_EOM_IRQ];
        msg_nxt.legacy_standard_select = wide_r & ctl_r[bcw_pkg::CW_LEGACY];
        unique case (ctl_r[bcw_pkg::CW_FMT_LO +: 3])
          3'h0: msg_nxt.fmt = i_mem_data[bcw_pkg::CMD_TR] ? bcw_pkg::FMT_RT_BC : bcw_pkg::FMT_BC_RT;
          3'h1: msg_nxt.fmt = bcw_pkg::FMT_TERMINAL_PAIR;
          3'h2: msg_nxt.fmt = bcw_pkg::FMT_BCST;
          3'h3: msg_nxt.fmt = bcw_pkg::FMT_BCST_PAIR;
          3'h4: msg_nxt.fmt = bcw_pkg::FMT_MODE;
          3'h6: msg_nxt.fmt = bcw_pkg::FMT_BCST_MODE;
          default: msg_nxt.fmt = bcw_pkg::FMT_UNUSED;
        endcase
        valid_nxt = 1'b1;
        state_nxt = bcw_pkg::ST_RUN;
      end
      bcw_pkg::ST_RUN: begin
        if (i_status_valid) begin
          // Set wins: a later clean status never hides an earlier exception of this attempt
          stat_set_nxt = stat_set_r | stat_check(i_status_word, ctl_r, cmd_r[15:11], wide_r,
                                                 cfg4_r[bcw_pkg::CF4_BMASK_EN]);
          me_nxt = me_r | i_status_word[bcw_pkg::SW_ME];
        end
        if (i_attempt_end) begin
          need = base_ok & (i_resp_timeout | i_format_error);
          need = need | (base_ok & cfg4_r[bcw_pkg::CF4_RETRY_STAT] & stat_set_nxt);
          need = need | (base_ok & cfg4_r[bcw_pkg::CF4_RETRY_LEGACY] & msg_r.legacy_standard_select & me_nxt);
          if (need && cnt_r < max_retry) begin
            retry_nxt = 1'b1;
            cnt_nxt = cnt_r + 2'h1;
            stat_set_nxt = 1'b0;
            me_nxt = 1'b0;
          end else begin
            done_nxt = 1'b1;
            valid_nxt = 1'b0;
            state_nxt = bcw_pkg::ST_IDLE;
          end
        end
      end
      default: state_nxt = bcw_pkg::ST_IDLE;
    endcase
  end

  // ********************************
  // Registers
  // ********************************
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_r <= bcw_pkg::ST_IDLE;
      ctl_r <= bcw_pkg::RST_CTL;
      cmd_r <= 16'h0000;
      base_r <= 16'h0000;
      cfg1_r <= bcw_pkg::RST_CFG;
      cfg3_r <= bcw_pkg::RST_CFG;
      cfg4_r <= bcw_pkg::RST_CFG;
      wide_r <= 1'b0;
      stat_set_r <= 1'b0;
      me_r <= 1'b0;
      cnt_r <= 2'h0;
      rdata_r <= 16'h0000;
      mem_rd_r <= 1'b0;
      mem_addr_r <= 16'h0000;
      tx_addr_r <= 16'h0000;
      mc_addr_r <= 16'h0000;
      msg_r <= '0;
      valid_r <= 1'b0;
      retry_r <= 1'b0;
      done_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      ctl_r <= ctl_nxt;
      cmd_r <= cmd_nxt;
      base_r <= base_nxt;
      cfg1_r <= cfg1_nxt;
      cfg3_r <= cfg3_nxt;
      cfg4_r <= cfg4_nxt;
      wide_r <= wide_nxt;
      stat_set_r <= stat_set_nxt;
      me_r <= me_nxt;
      cnt_r <= cnt_nxt;
      rdata_r <= rdata_nxt;
      mem_rd_r <= mem_rd_nxt;
      mem_addr_r <= mem_addr_nxt;
      tx_addr_r <= tx_addr_nxt;
      mc_addr_r <= mc_addr_nxt;
      msg_r <= msg_nxt;
      valid_r <= valid_nxt;
      retry_r <= retry_nxt;
      done_r <= done_nxt;
    end
  end

  assign o_reg_rdata = rdata_r;
  assign o_mem_rd = mem_rd_r;
  assign o_mem_addr = mem_addr_r;
  assign o_msg = msg_r;
  assign o_msg_valid = valid_r;
  assign o_tx_addr = tx_addr_r;
  assign o_mc_stat_addr = mc_addr_r;
  assign o_status_set = stat_set_r;
  assign o_retry = retry_r;
  assign o_msg_done = done_r;

  // ********************************
  // Checks
  // ********************************
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);

  fetch_first_a: assert property (state_r == bcw_pkg::ST_IDLE && i_msg_start |=>
    mem_rd_r && mem_addr_r == $past(i_msg_base) ##1 mem_rd_r && mem_addr_r == base_r + bcw_pkg::OFS_CMD)
    else $error("control word not fetched first");
  ctl_not_sent_a: assert property ($rose(valid_r) |-> tx_addr_r == base_r + bcw_pkg::OFS_CMD)
    else $error("bus traffic starts at control word");
  chan_pick_a: assert property (valid_r |-> msg_r.chan_a == ctl_r[bcw_pkg::CW_CHAN_A]
    && msg_r.tx_inhibit == ctl_r[bcw_pkg::CW_SELF_TEST])
    else $error("channel or self-test mismatch");
  short_form_a: assert property (valid_r && !wide_r |->
    !msg_r.end_of_msg_irq_en && !msg_r.legacy_standard_select)
    else $error("short form used wide bits");
  pair_fmt_a: assert property ($rose(valid_r) && ctl_r[2:0] == 3'h1 |-> msg_r.fmt == bcw_pkg::FMT_TERMINAL_PAIR)
    else $error("format decode wrong");
  short_stat_a: assert property (state_r == bcw_pkg::ST_RUN && !wide_r && i_status_valid && !stat_set_r
    && !i_attempt_end |=>
    stat_set_r == ($past(i_status_word[15:11]) != cmd_r[15:11] || |($past(i_status_word) & 16'h070F)
    || ($past(i_status_word[4]) != ctl_r[5])))
    else $error("short form status check wrong");
  me_mask_a: assert property (state_r == bcw_pkg::ST_RUN && wide_r && ctl_r[14] && !stat_set_r && i_status_valid
    && i_status_word == {cmd_r[15:11], 11'h400} && (cfg4_r[11] || !ctl_r[5]) |=> !stat_set_r)
    else $error("masked message error flagged");
  no_retry_a: assert property (state_r == bcw_pkg::ST_RUN && wide_r && !ctl_r[8] && i_attempt_end |=>
    !retry_r && done_r)
    else $error("retry with retry bit clear");
  retry_cap_a: assert property (retry_r |-> cnt_r <= max_retry && cnt_r != 2'h0)
    else $error("too many retries");
  legacy_retry_a: assert property (state_r == bcw_pkg::ST_RUN && i_attempt_end && cnt_r == 2'h0 && me_r
    && cfg1_r[4] && cfg4_r[10] && msg_r.legacy_standard_select && ctl_r[8] |=> retry_r)
    else $error("legacy message error not retried");
endmodule : bcw_ctrl

//--- sim/bcw_mem_model.sv
// Shared memory model holding message blocks as the host lays them out.
// Assumes the controller reads one word per strobe and takes it in the next cycle.
`timescale 1ns/100ps
module bcw_mem_model (
  // Clock
  input wire logic i_clk,
  // Host loading side
  input wire logic i_ld,
  input wire logic [7:0] i_ld_addr,
  input wire logic [15:0] i_ld_data,
  // Controller read side
  input wire logic i_rd,
  input wire logic [15:0] i_addr,
  output logic [15:0] o_data
);
  logic [15:0] mem_r [256];
  initial o_data = 16'h0000;
  // Host puts the control word first, the command word right after it
  always @(posedge i_clk) begin
    if (i_ld) begin
      mem_r[i_ld_addr] <= i_ld_data;
    end
  end
  // Data stand in the cycle after the strobe; toggling otherwise so a word taken one cycle late comes inverted
  always @(posedge i_clk) begin
    if (i_rd) begin
      o_data <= mem_r[i_addr[7:0]];
    end else begin
      o_data <= ~o_data;
    end
  end
endmodule : bcw_mem_model

//--- sim/testbench.sv
// Self-checking bench for the message control word interpreter.
// Assumes the memory model answers each read in the following cycle.
`timescale 1ns/100ps
module testbench;
  typedef struct packed {
    logic [15:0] cfg1;
    logic enh;
    logic [15:0] cfg4;
    logic [15:0] ctl;
    logic [15:0] cmd;
    logic [15:0] stat;
    logic to;
    logic fe;
    logic set;
    logic [1:0] nret;
  } bcw_row_s;
  logic i_clk = 1'b0;
  logic i_rst_n = 1'b0;
  logic [7:0] i_reg_addr = 8'h00;
  logic [15:0] i_reg_wdata = 16'h0000;
  logic i_reg_wr = 1'b0;
  logic i_reg_rd = 1'b0;
  logic i_msg_start = 1'b0;
  logic [15:0] i_msg_base = 16'h0000;
  logic i_status_valid = 1'b0;
  logic [15:0] i_status_word = 16'h0000;
  logic i_attempt_end = 1'b0;
  logic i_resp_timeout = 1'b0;
  logic i_format_error = 1'b0;
  logic ld = 1'b0;
  logic [7:0] ld_addr = 8'h00;
  logic [15:0] ld_data = 16'h0000;
  logic [15:0] o_reg_rdata, o_mem_addr, i_mem_data, o_tx_addr, o_mc_stat_addr;
  logic o_mem_rd, o_msg_valid, o_status_set, o_retry, o_msg_done;
  bcw_pkg::bcw_msg_s o_msg;
  int mismatches = 0;
  int compares = 0;
  int cycles = 0;
  logic [7:0] addrs [6] = '{8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h20};
  // cfg1, enhanced, cfg4, control, command, status, timeout, format error, status set, retries
  bcw_row_s rows [19] = '{
    '{16'h0000, 1'b0, 16'h0000, 16'h0080, 16'h2C00, 16'h2800, 1'b0, 1'b0, 1'b0, 2'h0},
    '{16'h0000, 1'b0, 16'h0000, 16'h0000, 16'h2800, 16'h3000, 1'b0, 1'b0, 1'b1, 2'h0},
    '{16'h0000, 1'b0, 16'h0000, 16'h0060, 16'h2C00, 16'h2800, 1'b0, 1'b0, 1'b1, 2'h0},
    '{16'h0000, 1'b0, 16'h0000, 16'h0020, 16'h2C00, 16'h2810, 1'b0, 1'b0, 1'b0, 2'h0},
    '{16'h0000, 1'b0, 16'h0000, 16'h7E01, 16'h2800, 16'h2801, 1'b0, 1'b0, 1'b1, 2'h0},
    '{16'h0010, 1'b0, 16'h0000, 16'h0002, 16'h2800, 16'h28E0, 1'b1, 1'b0, 1'b0, 2'h1},
    '{16'h0000, 1'b1, 16'h1000, 16'h7E07, 16'h2800, 16'h2DED, 1'b0, 1'b0, 1'b0, 2'h0},
    '{16'h0000, 1'b1, 16'h1000, 16'h3E01, 16'h2800, 16'h2DED, 1'b0, 1'b0, 1'b1, 2'h0},
    '{16'h0000, 1'b1, 16'h1000, 16'h5E02, 16'h2800, 16'h2DED, 1'b0, 1'b0, 1'b1, 2'h0},
    '{16'h0000, 1'b1, 16'h1000, 16'h6E03, 16'h2800, 16'h2DED, 1'b0, 1'b0, 1'b1, 2'h0},
    '{16'h0000, 1'b1, 16'h1000, 16'h7604, 16'h2800, 16'h2DED, 1'b0, 1'b0, 1'b1, 2'h0},
    '{16'h0000, 1'b1, 16'h1000, 16'h7A05, 16'h2800, 16'h2DED, 1'b0, 1'b0, 1'b1, 2'h0},
    '{16'h0000, 1'b1, 16'h1000, 16'h7C06, 16'h2800, 16'h2DED, 1'b0, 1'b0, 1'b1, 2'h0},
    '{16'h0018, 1'b1, 16'h1000, 16'h7F00, 16'h2800, 16'h2800, 1'b0, 1'b1, 1'b0, 2'h2},
    '{16'h0010, 1'b1, 16'h1000, 16'h7E00, 16'h2800, 16'h2800, 1'b1, 1'b0, 1'b0, 2'h0},
    '{16'h0010, 1'b1, 16'h1400, 16'h7F08, 16'h2800, 16'h2C00, 1'b0, 1'b0, 1'b0, 2'h1},
    '{16'h0010, 1'b1, 16'h1400, 16'h7F00, 16'h2800, 16'h2C00, 1'b0, 1'b0, 1'b0, 2'h0},
    '{16'h0000, 1'b0, 16'h1000, 16'h7E18, 16'h2800, 16'h2C00, 1'b0, 1'b0, 1'b1, 2'h0},
    '{16'h0010, 1'b1, 16'h1200, 16'h0100, 16'h2800, 16'h2801, 1'b0, 1'b0, 1'b1, 2'h1}
  };
  bcw_ctrl u_bcw_ctrl (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata),
    .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd), .o_reg_rdata(o_reg_rdata), .o_mem_rd(o_mem_rd),
    .o_mem_addr(o_mem_addr), .i_mem_data(i_mem_data), .i_msg_start(i_msg_start), .i_msg_base(i_msg_base),
    .i_status_valid(i_status_valid), .i_status_word(i_status_word), .i_attempt_end(i_attempt_end),
    .i_resp_timeout(i_resp_timeout), .i_format_error(i_format_error), .o_msg(o_msg), .o_msg_valid(o_msg_valid),
    .o_tx_addr(o_tx_addr), .o_mc_stat_addr(o_mc_stat_addr), .o_status_set(o_status_set), .o_retry(o_retry),
    .o_msg_done(o_msg_done));
  bcw_mem_model u_bcw_mem_model (.i_clk(i_clk), .i_ld(ld), .i_ld_addr(ld_addr), .i_ld_data(ld_data),
    .i_rd(o_mem_rd), .i_addr(o_mem_addr), .o_data(i_mem_data));
  always #4 i_clk = ~i_clk;
  // A hung handshake would otherwise stall the run forever
  always @(posedge i_clk) begin
    cycles <= cycles + 1;
    if (cycles == 8000) begin
      mismatches++;
      give_verdict();
    end
  end
  task automatic give_verdict();
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : give_verdict
  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : chk
  task automatic reg_wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge i_clk);
    i_reg_wr <= 1'b1;
    i_reg_addr <= a;
    i_reg_wdata <= d;
    @(posedge i_clk);
    i_reg_wr <= 1'b0;
  endtask : reg_wr
  task automatic reg_rd(input logic [7:0] a, output logic [15:0] d);
    @(posedge i_clk);
    i_reg_rd <= 1'b1;
    i_reg_addr <= a;
    @(posedge i_clk);
    i_reg_rd <= 1'b0;
    #1;
    d = o_reg_rdata;
  endtask : reg_rd
  task automatic mem_ld(input logic [7:0] a, input logic [15:0] d);
    @(posedge i_clk);
    ld <= 1'b1;
    ld_addr <= a;
    ld_data <= d;
    @(posedge i_clk);
    ld <= 1'b0;
  endtask : mem_ld
  function automatic bcw_pkg::bcw_msg_s exp_msg(input logic [15:0] c, input logic [15:0] cmd, input logic w);
    bcw_pkg::bcw_msg_s m;
    m.chan_a = c[7];
    m.tx_inhibit = c[6];
    m.loop_en = c[6];
    m.bcst_expect = c[5];
    m.end_of_msg_irq_en = w & c[4];
    m.legacy_standard_select = w & c[3];
    case (c[2:0])
      3'h0: m.fmt = cmd[10] ? bcw_pkg::FMT_RT_BC : bcw_pkg::FMT_BC_RT;
      3'h1: m.fmt = bcw_pkg::FMT_TERMINAL_PAIR;
      3'h2: m.fmt = bcw_pkg::FMT_BCST;
      3'h3: m.fmt = bcw_pkg::FMT_BCST_PAIR;
      3'h4: m.fmt = bcw_pkg::FMT_MODE;
      3'h6: m.fmt = bcw_pkg::FMT_BCST_MODE;
      default: m.fmt = bcw_pkg::FMT_UNUSED;
    endcase
    return m;
  endfunction : exp_msg
  task automatic start_msg(input logic [7:0] b, input logic [15:0] c, input logic [15:0] cmd, input logic w);
    mem_ld(b, c);
    mem_ld(b + 8'h01, cmd);
    @(posedge i_clk);
    i_msg_start <= 1'b1;
    i_msg_base <= {8'h00, b};
    @(posedge i_clk);
    i_msg_start <= 1'b0;
    for (int k = 0; k < 20 && o_msg_valid !== 1'b1; k++) begin
      @(posedge i_clk);
      #1;
    end
    chk({15'h0000, o_msg_valid}, 16'h0001, "msg valid");
    chk({7'h00, o_msg}, {7'h00, exp_msg(c, cmd, w)}, "decode");
    chk(o_tx_addr, {8'h00, b} + 16'h0001, "tx addr");
    chk(o_mc_stat_addr, {8'h00, b} + 16'h0003, "status slot");
  endtask : start_msg
  task automatic attempt(input bcw_row_s r, output logic rt, output logic dn);
    @(posedge i_clk);
    i_status_valid <= 1'b1;
    i_status_word <= r.stat;
    @(posedge i_clk);
    i_status_valid <= 1'b0;
    #1;
    chk({15'h0000, o_status_set}, {15'h0000, r.set}, "status set");
    @(posedge i_clk);
    i_attempt_end <= 1'b1;
    i_resp_timeout <= r.to;
    i_format_error <= r.fe;
    @(posedge i_clk);
    i_attempt_end <= 1'b0;
    #1;
    rt = o_retry;
    dn = o_msg_done;
  endtask : attempt
  task automatic run_row(input bcw_row_s r, input logic [7:0] b);
    logic rt;
    logic dn;
    logic [15:0] d;
    int n;
    n = 0;
    dn = 1'b0;
    reg_wr(bcw_pkg::ADDR_CFG1, r.cfg1);
    reg_wr(bcw_pkg::ADDR_CFG3, {r.enh, 15'h0000});
    reg_wr(bcw_pkg::ADDR_CFG4, r.cfg4);
    start_msg(b, r.ctl, r.cmd, r.enh & r.cfg4[12]);
    reg_rd(bcw_pkg::ADDR_CTL, d);
    chk(d, r.ctl, "latched control");
    for (int k = 0; k < 4 && dn !== 1'b1; k++) begin
      attempt(r, rt, dn);
      if (rt === 1'b1) n++;
    end
    chk(16'(n), {14'h0000, r.nret}, "retries");
    chk({15'h0000, dn}, 16'h0001, "done");
    chk({15'h0000, o_msg_valid}, 16'h0000, "valid after done");
  endtask : run_row
  initial begin
    logic [15:0] d;
    logic rt;
    logic dn;
    repeat (10) @(posedge i_clk);
    i_rst_n <= 1'b1;
    foreach (rows[i]) run_row(rows[i], 8'(i * 8));
    // Config change and control write mid-message must not reach the latched word
    start_msg(8'hC0, rows[6].ctl, rows[6].cmd, 1'b1);
    reg_wr(bcw_pkg::ADDR_CFG3, 16'h0000);
    reg_wr(bcw_pkg::ADDR_CTL, 16'h0000);
    reg_rd(bcw_pkg::ADDR_CTL, d);
    chk(d, rows[6].ctl, "control write while busy");
    attempt(rows[6], rt, dn);
    chk({15'h0000, dn}, 16'h0001, "latched done");
    @(posedge i_clk);
    i_rst_n <= 1'b0;
    repeat (3) @(posedge i_clk);
    #1;
    chk({5'h00, o_msg_valid, o_status_set, o_msg}, 16'h0000, "outputs in reset");
    chk({13'h0000, o_mem_rd, o_retry, o_msg_done}, 16'h0000, "pulses in reset");
    chk(o_mem_addr | o_tx_addr | o_mc_stat_addr, 16'h0000, "addresses in reset");
    @(posedge i_clk);
    i_rst_n <= 1'b1;
    foreach (addrs[i]) begin
      reg_rd(addrs[i], d);
      chk(d, 16'h0000, "reset value");
    end
    reg_wr(bcw_pkg::ADDR_STAT, 16'hFFFF);
    reg_rd(bcw_pkg::ADDR_STAT, d);
    chk(d, 16'h0000, "read-only status");
    give_verdict();
  end
endmodule : testbench
